// *** core/tcnt_ctl.sv ***
`timescale 1ns/1ps
// What this block does
// - One 8-bit control register and two 16-bit compare/capture registers govern it.
// - Both 16-bit timer registers reset to all ones.
// - Capture register always readable, writable only in pulse output mode.
// - Mode field: 00 timer family, 01 window, 10 pulse width, 11 pulse out.
// - Start 00 stops and clears; 01 command start; 10/11 edge selection.
// - Clock field picks slow, mid, fast divider tap or external pin.
// - New register value takes effect on first source tick after upper byte.
// - Lower byte write alone never changes the effective value.
// - Auto-capture works only in timer, event counter and window modes.
// - Stop power mode entry forces start field to 00 and halts counting.
// - Auto-capture copies the counter into capture register on each source tick.
// - External trigger: option 0 trigger start, 1 also stop on opposite edge.
// - Timer mode counts, on compare match raises request, clears, continues.
module tcnt_ctl (
    // Clock, reset, enable
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    // Register port
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // System divider taps and power state
    input wire logic TAP_SLOW_I,
    input wire logic TAP_MID_I,
    input wire logic TAP_FAST_I,
    input wire logic STOP_MODE_I,
    // External pin
    input wire logic EXT_PIN_I,
    // Status outputs
    output logic MATCH_IRQ_O,
    output logic RUNNING_O,
    output logic [15:0] COUNT_O,
    output logic OUT_FF_O
);
    logic [7:0] ctrl_q;
    logic [15:0] cmp_q;
    logic [15:0] cap_q;
    logic [7:0] cmp_lo_q;
    logic [7:0] cap_lo_q;
    logic [15:0] cmp_sh_q;
    logic [15:0] cap_sh_q;
    logic cmp_pend_q;
    logic cap_pend_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic run_q;
    logic run_d;
    logic irq_q;
    logic irq_d;
    logic ff_q;
    logic [7:0] rdata_q;
    logic pin_lvl;
    logic pin_rise;
    logic pin_fall;
    logic slow_lvl;
    logic mid_lvl;
    logic fast_lvl;
    logic slow_tick;
    logic mid_tick;
    logic fast_tick;
    logic [1:0] mode;
    logic [1:0] start;
    logic [1:0] clksel;
    logic opt;
    logic tick;
    logic trig_edge;
    logic anti_edge;
    logic is_timer;
    logic match;
    logic cap_en;
    logic stop_prev_q;

    assign mode = ctrl_q[tcnt_pkg::MODE_HI:tcnt_pkg::MODE_LO];
    assign start = ctrl_q[tcnt_pkg::START_HI:tcnt_pkg::START_LO];
    assign clksel = ctrl_q[tcnt_pkg::CLK_HI:tcnt_pkg::CLK_LO];
    assign opt = ctrl_q[tcnt_pkg::OPT_BIT];

    // Pin and divider taps come from outside, so each gets a synchroniser
    tcnt_sync u_sync_pin (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .pin_i(EXT_PIN_I),
        .level_o(pin_lvl)
    );
    tcnt_sync u_sync_slow (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .pin_i(TAP_SLOW_I),
        .level_o(slow_lvl)
    );
    tcnt_sync u_sync_mid (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .pin_i(TAP_MID_I),
        .level_o(mid_lvl)
    );
    tcnt_sync u_sync_fast (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .pin_i(TAP_FAST_I),
        .level_o(fast_lvl)
    );
    tcnt_tick u_tick_pin (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .level_i(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );
    tcnt_tick u_tick_slow (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .level_i(slow_lvl),
        .rise_o(slow_tick),
        .fall_o()
    );
    tcnt_tick u_tick_mid (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .level_i(mid_lvl),
        .rise_o(mid_tick),
        .fall_o()
    );
    tcnt_tick u_tick_fast (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .en_i(CE_I),
        .level_i(fast_lvl),
        .rise_o(fast_tick),
        .fall_o()
    );

    // Source tick selection
    always_comb begin
        unique case (clksel)
            tcnt_pkg::CLK_SLOW: tick = slow_tick;
            tcnt_pkg::CLK_MID: tick = mid_tick;
            tcnt_pkg::CLK_FAST: tick = fast_tick;
            tcnt_pkg::CLK_PIN: tick = pin_rise;
        endcase
    end

    // Trigger edges follow the start field polarity
    assign trig_edge = (start == tcnt_pkg::START_FALL) ? pin_fall : pin_rise;
    assign anti_edge = (start == tcnt_pkg::START_FALL) ? pin_rise : pin_fall;
    // Timer mode proper is mode 00 with command start on an internal clock
    assign is_timer = (mode == tcnt_pkg::MODE_TIMER) && (clksel != tcnt_pkg::CLK_PIN);
    assign match = (cnt_q == cmp_q);
    // capture only in timer, event and window modes
    assign cap_en = opt && start != tcnt_pkg::START_STOP
        && ((mode == tcnt_pkg::MODE_TIMER
             && (start == tcnt_pkg::START_CMD || clksel == tcnt_pkg::CLK_PIN))
            || mode == tcnt_pkg::MODE_WINDOW);

    // Control register; stop-mode entry forces the start field to stop
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            ctrl_q <= tcnt_pkg::CTRL_RESET;
            stop_prev_q <= 1'b0;
        end else if (CE_I) begin
            stop_prev_q <= STOP_MODE_I;
            if (WR_I && ADDR_I == tcnt_pkg::ADDR_CTRL) begin
                ctrl_q <= WDATA_I;
            end
            // stop entry clears start, wins over a write
            if (STOP_MODE_I && !stop_prev_q) begin
                ctrl_q[tcnt_pkg::START_HI:tcnt_pkg::START_LO] <= tcnt_pkg::START_STOP;
            end
        end
    end

    // Byte staging: lower byte latched, upper byte forms the shadow value
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            cmp_lo_q <= tcnt_pkg::TREG_RESET[7:0];
            cap_lo_q <= tcnt_pkg::TREG_RESET[7:0];
            cmp_sh_q <= tcnt_pkg::TREG_RESET;
            cap_sh_q <= tcnt_pkg::TREG_RESET;
            cmp_pend_q <= 1'b0;
            cap_pend_q <= 1'b0;
        end else if (CE_I) begin
            if (WR_I && ADDR_I == tcnt_pkg::ADDR_CMP_LO) begin
                cmp_lo_q <= WDATA_I;
            end
            if (WR_I && ADDR_I == tcnt_pkg::ADDR_CMP_HI) begin
                cmp_sh_q <= {WDATA_I, cmp_lo_q};
                cmp_pend_q <= 1'b1;
            end else if (tick) begin
                cmp_pend_q <= 1'b0;
            end
            // second register writable only in pulse output mode
            if (WR_I && ADDR_I == tcnt_pkg::ADDR_CAP_LO && mode == tcnt_pkg::MODE_PPG) begin
                cap_lo_q <= WDATA_I;
            end
            if (WR_I && ADDR_I == tcnt_pkg::ADDR_CAP_HI && mode == tcnt_pkg::MODE_PPG) begin
                cap_sh_q <= {WDATA_I, cap_lo_q};
                cap_pend_q <= 1'b1;
            end else if (tick) begin
                cap_pend_q <= 1'b0;
            end
        end
    end

    // Effective registers
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            cmp_q <= tcnt_pkg::TREG_RESET;
            cap_q <= tcnt_pkg::TREG_RESET;
        end else if (CE_I) begin
            // pending value loads on next source tick
            if (tick && cmp_pend_q) begin
                cmp_q <= cmp_sh_q;
            end
            if (tick && cap_pend_q) begin
                cap_q <= cap_sh_q;
            end else if (tick && cap_en) begin
                // capture running count each source tick
                cap_q <= cnt_q;
            end
        end
    end

    // Counter sequencing per mode
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        irq_d = 1'b0;
        if (start == tcnt_pkg::START_STOP) begin
            cnt_d = tcnt_pkg::COUNT_ZERO;
            run_d = 1'b0;
        end else if (is_timer && start == tcnt_pkg::START_CMD) begin
            // free count with clear on match
            run_d = 1'b1;
            if (tick) begin
                if (match) begin
                    cnt_d = tcnt_pkg::COUNT_ZERO;
                    irq_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + tcnt_pkg::COUNT_ONE;
                end
            end
        end else if (mode == tcnt_pkg::MODE_TIMER && clksel == tcnt_pkg::CLK_PIN) begin
            // Event counter: count selected pin edge
            run_d = 1'b1;
            if (trig_edge) begin
                cnt_d = cnt_q + tcnt_pkg::COUNT_ONE;
            end
            if (anti_edge && match) begin
                cnt_d = tcnt_pkg::COUNT_ZERO;
                irq_d = 1'b1;
            end
        end else if (mode == tcnt_pkg::MODE_TIMER && start != tcnt_pkg::START_CMD) begin
            // trigger start, optional stop on opposite edge
            if (!run_q && trig_edge) begin
                run_d = 1'b1;
            end else if (run_q && opt && anti_edge) begin
                run_d = 1'b0;
                cnt_d = tcnt_pkg::COUNT_ZERO;
            end else if (run_q && tick) begin
                if (match) begin
                    run_d = 1'b0;
                    cnt_d = tcnt_pkg::COUNT_ZERO;
                    irq_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + tcnt_pkg::COUNT_ONE;
                end
            end
        end else if (mode == tcnt_pkg::MODE_WINDOW) begin
            // Window: count while pin at active level
            run_d = (start == tcnt_pkg::START_FALL) ? !pin_lvl : pin_lvl;
            if (run_q && tick) begin
                if (match) begin
                    cnt_d = tcnt_pkg::COUNT_ZERO;
                    irq_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + tcnt_pkg::COUNT_ONE;
                end
            end
        end else begin
            // pulse width and pulse output run from trigger or command
            // option selects continuous run or one-shot stop at match
            if (!run_q && (trig_edge || start == tcnt_pkg::START_CMD)) begin
                run_d = 1'b1;
            end else if (run_q && tick) begin
                if (match) begin
                    cnt_d = tcnt_pkg::COUNT_ZERO;
                    irq_d = 1'b1;
                    run_d = !opt;
                end else begin
                    cnt_d = cnt_q + tcnt_pkg::COUNT_ONE;
                end
            end
        end
    end

    // Counter state
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            cnt_q <= tcnt_pkg::COUNT_ZERO;
            run_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (CE_I) begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            irq_q <= irq_d;
        end
    end

    // Output flip-flop: preset from init bit while stopped, toggles at match points in pulse output mode only
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            ff_q <= 1'b0;
        end else if (CE_I) begin
            if (start == tcnt_pkg::START_STOP) begin
                ff_q <= ctrl_q[tcnt_pkg::FF_BIT];
            end else if (mode == tcnt_pkg::MODE_PPG && run_q && tick
                         && (match || cnt_q == cap_q)) begin
                ff_q <= ~ff_q;
            end
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            rdata_q <= 8'h00;
        end else if (CE_I) begin
            rdata_q <= 8'h00;
            if (RD_I) begin
                unique case (ADDR_I)
                    tcnt_pkg::ADDR_CMP_LO: rdata_q <= cmp_q[7:0];
                    tcnt_pkg::ADDR_CMP_HI: rdata_q <= cmp_q[15:8];
                    tcnt_pkg::ADDR_CAP_LO: rdata_q <= cap_q[7:0];
                    tcnt_pkg::ADDR_CAP_HI: rdata_q <= cap_q[15:8];
                    tcnt_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign RDATA_O = rdata_q;
    assign MATCH_IRQ_O = irq_q;
    assign RUNNING_O = run_q;
    assign COUNT_O = cnt_q;
    assign OUT_FF_O = ff_q;
endmodule

// *** core/tcnt_pkg.sv ***
package tcnt_pkg;
    // Register byte addresses (8-bit CPU bus)
    localparam logic [15:0] ADDR_CMP_LO = 16'h0010;
    localparam logic [15:0] ADDR_CMP_HI = 16'h0011;
    localparam logic [15:0] ADDR_CAP_LO = 16'h0012;
    localparam logic [15:0] ADDR_CAP_HI = 16'h0013;
    localparam logic [15:0] ADDR_CTRL = 16'h0014;
    // Reset values
    localparam logic [15:0] TREG_RESET = 16'hFFFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Control field positions
    localparam int FF_BIT = 7;
    localparam int OPT_BIT = 6;
    localparam int START_HI = 5;
    localparam int START_LO = 4;
    localparam int CLK_HI = 3;
    localparam int CLK_LO = 2;
    localparam int MODE_HI = 1;
    localparam int MODE_LO = 0;
    // Field encodings
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_WINDOW = 2'h1;
    localparam logic [1:0] MODE_PULSE = 2'h2;
    localparam logic [1:0] MODE_PPG = 2'h3;
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_CMD = 2'h1;
    localparam logic [1:0] START_RISE = 2'h2;
    localparam logic [1:0] START_FALL = 2'h3;
    localparam logic [1:0] CLK_SLOW = 2'h0;
    localparam logic [1:0] CLK_MID = 2'h1;
    localparam logic [1:0] CLK_FAST = 2'h2;
    localparam logic [1:0] CLK_PIN = 2'h3;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
endpackage

// *** core/tcnt_sync.sv ***
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages two and three agree
module tcnt_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Shift chain; first stage is read by the second only
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_o <= 1'b0;
        end else if (en_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end
endmodule

// *** core/tcnt_tick.sv ***
`timescale 1ns/1ps
// Rising- and falling-edge detector on a same-clock level, one-cycle ticks out
module tcnt_tick (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);
    logic prev_q;

    // Previous level for edge compare
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prev_q <= 1'b0;
        end else if (en_i) begin
            prev_q <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_q;
    assign fall_o = ~level_i & prev_q;
endmodule

// *** tb/tcnt_ctl_checker.sv ***
`timescale 1ns/1ps
module tcnt_ctl_checker (
    // Clock, reset, enable
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    // Register port
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    // Taps, power state, pin
    input wire logic TAP_SLOW_I,
    input wire logic TAP_MID_I,
    input wire logic TAP_FAST_I,
    input wire logic STOP_MODE_I,
    input wire logic EXT_PIN_I,
    // Status
    input wire logic MATCH_IRQ_O,
    input wire logic RUNNING_O,
    input wire logic [15:0] COUNT_O,
    input wire logic OUT_FF_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    // Decode of the five register bytes
    logic mapped;
    assign mapped = (ADDR_I >= tcnt_pkg::ADDR_CMP_LO) && (ADDR_I <= tcnt_pkg::ADDR_CTRL);

    // Register port answers
    a_rdata_idle: assert property (CE_I && !RD_I |=> RDATA_O == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (CE_I && RD_I && !mapped |=> RDATA_O == 8'h00)
        else $error("unmapped read returned nonzero data");

    // Compare match behaviour
    a_irq_pulse: assert property (MATCH_IRQ_O |=> !MATCH_IRQ_O)
        else $error("match request longer than one cycle");
    a_irq_cleared: assert property (MATCH_IRQ_O |-> COUNT_O == tcnt_pkg::COUNT_ZERO)
        else $error("counter not cleared at match request");
    a_irq_running: assert property (MATCH_IRQ_O |-> $past(RUNNING_O, 2))
        else $error("match request without a running counter");

    // Counting and stopping
    a_count_step: assert property ($changed(COUNT_O) |->
        COUNT_O == $past(COUNT_O) + 16'h0001 || COUNT_O == 16'h0000)
        else $error("counter moved by other than one or clear");
    a_stop_write: assert property (CE_I && WR_I && ADDR_I == tcnt_pkg::ADDR_CTRL &&
        WDATA_I[5:4] == tcnt_pkg::START_STOP |-> ##[1:2] !RUNNING_O && COUNT_O == 16'h0000)
        else $error("stop command did not halt and clear");
    a_idle_frozen: assert property (!RUNNING_O [*3] |-> $stable(COUNT_O))
        else $error("counter changed while halted");
    a_stop_halt: assert property ($rose(STOP_MODE_I) |-> ##[1:6] !RUNNING_O)
        else $error("stop power mode did not halt counter");

    // Main scenarios reached
    c_match: cover property (MATCH_IRQ_O);
    c_stop: cover property ($rose(STOP_MODE_I));
    c_unmapped: cover property (RD_I && !mapped);
endmodule

bind tcnt_ctl tcnt_ctl_checker chk (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TAP_SLOW_I(TAP_SLOW_I), .TAP_MID_I(TAP_MID_I), .TAP_FAST_I(TAP_FAST_I),
    .STOP_MODE_I(STOP_MODE_I), .EXT_PIN_I(EXT_PIN_I), .MATCH_IRQ_O(MATCH_IRQ_O),
    .RUNNING_O(RUNNING_O), .COUNT_O(COUNT_O), .OUT_FF_O(OUT_FF_O));

// *** tb/tb_tcnt_ctl.sv ***
`timescale 1ns/1ps
module tb_tcnt_ctl;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tap = 1'b0;
    logic stop = 1'b0;
    logic ce = 1'b1;
    logic pin = 1'b0;
    logic [7:0] rdata;
    logic irq;
    logic running;
    logic out_ff;
    logic [15:0] count;
    logic [7:0] expq[$];
    logic rd_seen = 1'b0;
    logic [7:0] r;
    int failures = 0;
    int compares = 0;
    int irqs = 0;

    // Free-running core clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Slow and mid taps share one stimulus; the fast tap follows the pin so selection shows
    tcnt_ctl uut (.CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TAP_SLOW_I(tap),
        .TAP_MID_I(tap), .TAP_FAST_I(pin), .STOP_MODE_I(stop), .EXT_PIN_I(pin),
        .MATCH_IRQ_O(irq), .RUNNING_O(running), .COUNT_O(count), .OUT_FF_O(out_ff));

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Each bus task owns both strobes for one cycle, so no strobe is set twice in a step
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rreg(input logic [15:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        expq.push_back(exp);
        @(posedge clk);
    endtask

    // Tap held high and low long enough to pass the synchroniser
    task automatic tick();
        wr <= 1'b0;
        rd <= 1'b0;
        tap <= 1'b1;
        repeat (8) @(posedge clk);
        tap <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // Pin held long enough to pass the synchroniser, strobes released
    task automatic pin_set(input logic v);
        wr <= 1'b0;
        rd <= 1'b0;
        pin <= v;
        repeat (8) @(posedge clk);
    endtask

    // Read data answer the cycle after the strobe; oldest note is the expectation
    always @(posedge clk) begin
        if (rd_seen)
            check(16'(rdata), 16'(expq.pop_front()), "read data");
        rd_seen <= rd;
        if (irq === 1'b1)
            irqs++;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("BAD %0t run did not finish", $time);
        final_report();
    end

    // Main sequence
    initial begin
        // Top bit cleared so the staged byte always differs from the reset byte
        r = 8'($urandom(29)) & 8'h7F;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rreg(tcnt_pkg::ADDR_CMP_LO, 8'hFF);
        rreg(tcnt_pkg::ADDR_CMP_HI, 8'hFF);
        rreg(tcnt_pkg::ADDR_CAP_LO, 8'hFF);
        rreg(tcnt_pkg::ADDR_CAP_HI, 8'hFF);
        rreg(tcnt_pkg::ADDR_CTRL, tcnt_pkg::CTRL_RESET);
        rreg(16'h0020, 8'h00);
        // Every mode and clock code written and read back while stopped
        for (int m = 0; m < 4; m++) begin
            wreg(tcnt_pkg::ADDR_CTRL, 8'(m * 5));
            rreg(tcnt_pkg::ADDR_CTRL, 8'(m * 5));
        end
        // Capture register refuses writes outside pulse output mode
        wreg(tcnt_pkg::ADDR_CTRL, 8'h00);
        wreg(tcnt_pkg::ADDR_CAP_LO, r);
        wreg(tcnt_pkg::ADDR_CAP_HI, ~r);
        tick();
        rreg(tcnt_pkg::ADDR_CAP_LO, 8'hFF);
        rreg(tcnt_pkg::ADDR_CAP_HI, 8'hFF);
        // Pulse output mode: lower byte alone, then upper byte, then the tick
        wreg(tcnt_pkg::ADDR_CTRL, 8'h03);
        wreg(tcnt_pkg::ADDR_CAP_LO, r);
        tick();
        rreg(tcnt_pkg::ADDR_CAP_LO, 8'hFF);
        wreg(tcnt_pkg::ADDR_CAP_HI, 8'h12);
        rreg(tcnt_pkg::ADDR_CAP_LO, 8'hFF);
        tick();
        rreg(tcnt_pkg::ADDR_CAP_LO, r);
        rreg(tcnt_pkg::ADDR_CAP_HI, 8'h12);
        // Timer mode with compare value three, command start
        wreg(tcnt_pkg::ADDR_CTRL, 8'h00);
        wreg(tcnt_pkg::ADDR_CMP_LO, 8'h03);
        wreg(tcnt_pkg::ADDR_CMP_HI, 8'h00);
        tick();
        rreg(tcnt_pkg::ADDR_CMP_LO, 8'h03);
        wreg(tcnt_pkg::ADDR_CTRL, 8'h10);
        repeat (3) tick();
        check(count, 16'h0003, "count before match");
        check(16'(irqs), 16'h0000, "early match");
        tick();
        check(count, 16'h0000, "count after match");
        check(16'(irqs), 16'h0001, "match requests");
        tick();
        check(count, 16'h0001, "count keeps going");
        rreg(tcnt_pkg::ADDR_CAP_HI, 8'h12);
        // Start field 00 stops and clears
        wreg(tcnt_pkg::ADDR_CTRL, 8'h00);
        tick();
        check(count, 16'h0000, "cleared count");
        check(16'(running), 16'h0000, "stopped flag");
        // Auto-capture copies the small running count
        wreg(tcnt_pkg::ADDR_CTRL, 8'h50);
        repeat (2) tick();
        rreg(tcnt_pkg::ADDR_CAP_HI, 8'h00);
        rreg(tcnt_pkg::ADDR_CAP_LO, 8'h01);
        // Stop power mode forces the start field back to 00
        stop <= 1'b1;
        wr <= 1'b0;
        rd <= 1'b0;
        for (int i = 0; i < 20 && running !== 1'b0; i++)
            @(posedge clk);
        check(16'(running), 16'h0000, "stop mode halt");
        rreg(tcnt_pkg::ADDR_CTRL, 8'h40);
        stop <= 1'b0;
        rd <= 1'b0;
        repeat (4) @(posedge clk);
        check(count, 16'h0000, "count after stop mode");
        // Event counter: rising pin edges count, a match clears on the falling edge
        wreg(tcnt_pkg::ADDR_CTRL, 8'h2C);
        repeat (2) begin
            pin_set(1'b1);
            pin_set(1'b0);
        end
        pin_set(1'b1);
        check(count, 16'h0003, "event count");
        pin_set(1'b0);
        check(count, 16'h0000, "event match clear");
        check(16'(irqs), 16'h0002, "event match request");
        // External trigger with stop on the opposite edge; enable low freezes the run
        wreg(tcnt_pkg::ADDR_CTRL, 8'h00);
        wreg(tcnt_pkg::ADDR_CTRL, 8'h60);
        pin_set(1'b1);
        check(16'(running), 16'h0001, "trigger start");
        repeat (2) tick();
        check(count, 16'h0002, "trigger count");
        ce <= 1'b0;
        tick();
        check(count, 16'h0002, "frozen by enable");
        ce <= 1'b1;
        pin_set(1'b0);
        check(count, 16'h0000, "opposite edge clear");
        check(16'(running), 16'h0000, "opposite edge halt");
        check(16'(irqs), 16'h0002, "no request on early stop");
        // Fast tap selected: slow tap ticks are ignored, the pin-driven fast tap counts
        wreg(tcnt_pkg::ADDR_CTRL, 8'h00);
        wreg(tcnt_pkg::ADDR_CTRL, 8'h18);
        tick();
        check(count, 16'h0000, "unselected tap");
        pin_set(1'b1);
        pin_set(1'b0);
        check(count, 16'h0001, "fast tap count");
        // Output flip-flop presets from the init bit while stopped: one with 0x83, zero with 0x00
        wreg(tcnt_pkg::ADDR_CTRL, 8'h00);
        wreg(tcnt_pkg::ADDR_CTRL, 8'h83);
        rreg(tcnt_pkg::ADDR_CTRL, 8'h83);
        pin_set(1'b0);
        check(16'(out_ff), 16'h0001, "flip-flop preset");
        wreg(tcnt_pkg::ADDR_CTRL, 8'h00);
        pin_set(1'b0);
        check(16'(out_ff), 16'h0000, "flip-flop cleared");
        final_report();
    end
endmodule
